/* core/per_recorder.sv */
// per_recorder: program event recorder with apb registers and fixed-area writes.
// assumes the core pulses one instruction-complete strobe with event qualifiers,
// and that the fixed-area storage port accepts a byte whenever fa_ready is high.
// registers sit at word offsets on an 8-bit apb address and answer with no wait state.
//
// Contract
// - record only in extended control mode with status word bit 1 set
// - select register bits 0 to 3 enable the four event types
// - interrupt only when recording mask and that type's enable are set
// - select register bits 16 to 31 choose which general registers count
// - watched range start and end come from the start and end registers
// - detect branch taken, register change, fetch in range, store in range
// - write the event type code to fixed storage byte 150
// - write the instruction address to fixed storage bytes 153 to 155
// - events while masked or disabled are dropped, never held pending
// - with translation on, bounds compare against virtual references
`timescale 1ns/1ps
module per_recorder #(
    parameter int AW = 24
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // status word state from the core
    input wire logic extended_control_mode,
    input wire logic program_status_word_bit1,
    input wire logic translation_on,
    // instruction completion and its events
    input wire logic insn_done,
    input wire logic [AW-1:0] insn_addr,
    input wire logic branch_taken,
    input wire logic [per_pkg::PER_NUM_GREGS-1:0] greg_written,
    input wire logic fetch_valid,
    input wire logic [AW-1:0] fetch_real_addr,
    input wire logic [AW-1:0] fetch_virt_addr,
    input wire logic store_valid,
    input wire logic [AW-1:0] store_real_addr,
    input wire logic [AW-1:0] store_virt_addr,
    // fixed-area storage write port
    output logic fa_we,
    output logic [11:0] fa_addr,
    output logic [7:0] fa_data,
    input wire logic fa_ready,
    // program interruption
    output logic per_irq
);
    import per_pkg::*;

    logic [31:0] sel_reg, start_reg, end_reg;
    logic [3:0] status, mask, code;
    logic [AW-1:0] addr_hold;
    logic [31:0] next_sel_reg, next_start_reg, next_end_reg;
    logic [3:0] next_status, next_mask, next_code;
    logic [AW-1:0] next_addr_hold;
    per_state_t state, next_state;
    logic [11:0] next_fa_addr;
    logic [7:0] next_fa_data;
    logic next_fa_we;
    logic wr_acc, rd_acc, addr_ok;
    logic fetch_hit, store_hit;
    logic [AW-1:0] fetch_ref, store_ref;
    logic [3:0] raw_ev, ev;
    logic active, fire;

    // apb: single-cycle access phase, no wait states
    assign pready = 1'b1;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    always_comb begin
        unique case (paddr)
            PER_OFF_SELECT, PER_OFF_START, PER_OFF_END, PER_OFF_STATUS,
            PER_OFF_MASK, PER_OFF_CODE, PER_OFF_ADDR: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addr_ok;

    // virtual compare
    // pick the address space the bounds are meant for
    assign fetch_ref = translation_on ? fetch_virt_addr : fetch_real_addr;
    assign store_ref = translation_on ? store_virt_addr : store_real_addr;

    // range bounds
    // one comparator per reference kind, both fed by the same bounds
    per_range_cmp #(.AW(AW)) u_fetch_cmp (
        .range_start(start_reg[AW-1:0]),
        .range_end(end_reg[AW-1:0]),
        .addr(fetch_ref),
        .hit(fetch_hit)
    );
    per_range_cmp #(.AW(AW)) u_store_cmp (
        .range_start(start_reg[AW-1:0]),
        .range_end(end_reg[AW-1:0]),
        .addr(store_ref),
        .hit(store_hit)
    );

    always_comb begin
        raw_ev = 4'h0;
        raw_ev[PER_EN_BRANCH] = branch_taken;
        raw_ev[PER_EN_GREG] = |(greg_written & sel_reg[PER_GSEL_LSB +: PER_NUM_GREGS]);
        raw_ev[PER_EN_FETCH] = fetch_valid && fetch_hit;
        raw_ev[PER_EN_STORE] = store_valid && store_hit;
    end

    assign active = extended_control_mode && program_status_word_bit1;
    // drop masked events
    // masked events are simply not qualified; nothing latches them
    assign ev = (insn_done && active) ? (raw_ev & sel_reg[3:0]) : 4'h0;
    // interrupt condition
    // a new event is not taken while the previous one is still being stored
    assign fire = (|ev) && (state == PER_IDLE);

    // registers, status and captured event
    always_comb begin
        next_sel_reg = sel_reg;
        next_start_reg = start_reg;
        next_end_reg = end_reg;
        next_mask = mask;
        next_status = status;
        next_code = code;
        next_addr_hold = addr_hold;
        if (wr_acc) begin
            unique case (paddr)
                PER_OFF_SELECT: next_sel_reg = pwdata;
                PER_OFF_START: next_start_reg = pwdata;
                PER_OFF_END: next_end_reg = pwdata;
                PER_OFF_MASK: next_mask = pwdata[3:0];
                default: ;
            endcase
        end
        // read of status clears only the bits handed out in prdata, so an event
        // landing between setup and access is not lost;
        // a new event in the same cycle still sets
        if (rd_acc && paddr == PER_OFF_STATUS) begin
            next_status = status & ~prdata[3:0];
        end
        if (fire) begin
            next_status = next_status | ev;
            next_code = ev;
            next_addr_hold = insn_addr;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_reg <= PER_RST_REG;
            start_reg <= PER_RST_REG;
            end_reg <= PER_RST_REG;
            mask <= PER_RST_NIB;
            status <= PER_RST_NIB;
            code <= PER_RST_NIB;
            addr_hold <= '0;
        end else begin
            sel_reg <= next_sel_reg;
            start_reg <= next_start_reg;
            end_reg <= next_end_reg;
            mask <= next_mask;
            status <= next_status;
            code <= next_code;
            addr_hold <= next_addr_hold;
        end
    end

    // read data registered in setup phase so it is stable in access
    logic [31:0] next_prdata;
    always_comb begin
        next_prdata = 32'h00000000;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                PER_OFF_SELECT: next_prdata = sel_reg;
                PER_OFF_START: next_prdata = start_reg;
                PER_OFF_END: next_prdata = end_reg;
                PER_OFF_STATUS: next_prdata = {28'h0000000, status};
                PER_OFF_MASK: next_prdata = {28'h0000000, mask};
                PER_OFF_CODE: next_prdata = {28'h0000000, code};
                PER_OFF_ADDR: next_prdata = {{(32-AW){1'b0}}, addr_hold};
                default: next_prdata = 32'h00000000;
            endcase
        end else begin
            next_prdata = prdata;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else begin
            prdata <= next_prdata;
        end
    end

    // level interrupt from unmasked sticky bits
    assign per_irq = |(status & mask);

    // fixed-area sequencer: code byte, then three address bytes high first
    // bytes come from the captured address: the core has moved on by then
    always_comb begin
        next_state = state;
        next_fa_we = fa_we;
        next_fa_addr = fa_addr;
        next_fa_data = fa_data;
        unique case (state)
            PER_IDLE: begin
                next_fa_we = 1'b0;
                if (fire) begin
                    next_state = PER_WR_CODE;
                    next_fa_we = 1'b1;
                    next_fa_addr = PER_LOC_CODE;
                    next_fa_data = {4'h0, ev};
                end
            end
            PER_WR_CODE: begin
                if (fa_ready) begin
                    next_state = PER_WR_A0;
                    next_fa_addr = PER_LOC_ADDR;
                    next_fa_data = addr_hold[23:16];
                end
            end
            PER_WR_A0: begin
                if (fa_ready) begin
                    next_state = PER_WR_A1;
                    next_fa_addr = PER_LOC_ADDR + 12'h001;
                    next_fa_data = addr_hold[15:8];
                end
            end
            PER_WR_A1: begin
                if (fa_ready) begin
                    next_state = PER_WR_A2;
                    next_fa_addr = PER_LOC_ADDR + 12'h002;
                    next_fa_data = addr_hold[7:0];
                end
            end
            PER_WR_A2: begin
                if (fa_ready) begin
                    next_state = PER_IDLE;
                    next_fa_we = 1'b0;
                end
            end
            default: next_state = PER_IDLE;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PER_IDLE;
            fa_we <= 1'b0;
            fa_addr <= 12'h000;
            fa_data <= 8'h00;
        end else begin
            state <= next_state;
            fa_we <= next_fa_we;
            fa_addr <= next_fa_addr;
            fa_data <= next_fa_data;
        end
    end

    // checks: gating and capture of events
    a_mode_gate: assert property (@(posedge pclk) disable iff (!presetn)
        fire |-> extended_control_mode && program_status_word_bit1)
        else $error("event taken outside recording mode");
    a_enable_gate: assert property (@(posedge pclk) disable iff (!presetn)
        fire |=> ((code & ~$past(sel_reg[3:0])) == 4'h0))
        else $error("disabled event type recorded");
    a_irq_cause: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(per_irq) |-> $past(fire) || $changed(mask))
        else $error("interrupt without event or mask change");
    a_greg_sel: assert property (@(posedge pclk) disable iff (!presetn)
        (fire && ((greg_written & sel_reg[31:16]) == 16'h0000)) |=> !code[PER_EN_GREG])
        else $error("unselected register change recorded");
    a_code_byte: assert property (@(posedge pclk) disable iff (!presetn)
        fire |=> fa_we && fa_addr == 12'h096 && fa_data[3:0] == code)
        else $error("code byte not written to 150");
    a_addr_bytes: assert property (@(posedge pclk) disable iff (!presetn)
        (state == PER_WR_A2 && fa_we) |-> fa_addr == 12'h09b && fa_data == addr_hold[7:0])
        else $error("last address byte not at 155");
    a_no_pending: assert property (@(posedge pclk) disable iff (!presetn)
        (insn_done && !active) |=> status == ($past(status) & ~({4{$past(rd_acc &&
        paddr == PER_OFF_STATUS)}} & $past(prdata[3:0]))))
        else $error("masked event left a trace");
    a_merge_code: assert property (@(posedge pclk) disable iff (!presetn)
        fire |=> code == $past(ev))
        else $error("events of one instruction not merged");
    a_seq_len: assert property (@(posedge pclk) disable iff (!presetn)
        (fire && fa_ready) ##1 fa_ready [*4] |-> ##1 state == PER_IDLE)
        else $error("fixed-area sequence not four bytes");

    // range compare, checked against the bounds directly
    a_range_fetch: assert property (@(posedge pclk) disable iff (!presetn)
        (fire && ev[PER_EN_FETCH] && start_reg[AW-1:0] <= end_reg[AW-1:0]) |->
        (fetch_ref >= start_reg[AW-1:0]) && (fetch_ref <= end_reg[AW-1:0]))
        else $error("fetch outside watched range recorded");
    a_range_virt: assert property (@(posedge pclk) disable iff (!presetn)
        (fire && ev[PER_EN_STORE] && translation_on && start_reg[AW-1:0] <= end_reg[AW-1:0])
        |-> (store_virt_addr >= start_reg[AW-1:0]) && (store_virt_addr <= end_reg[AW-1:0]))
        else $error("store range not compared on virtual address");

    // fixed-area write-out
    a_addr_first: assert property (@(posedge pclk) disable iff (!presetn)
        (state == PER_WR_A0 && fa_we) |-> fa_addr == 12'h099 && fa_data == addr_hold[23:16])
        else $error("first address byte not at 153");
    a_addr_mid: assert property (@(posedge pclk) disable iff (!presetn)
        (state == PER_WR_A1 && fa_we) |-> fa_addr == 12'h09a && fa_data == addr_hold[15:8])
        else $error("middle address byte not at 154");
    a_byte_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (fa_we && !fa_ready) |=> fa_we && $stable(fa_addr) && $stable(fa_data))
        else $error("stalled fixed-area byte not held");
    a_code_stable: assert property (@(posedge pclk) disable iff (!presetn)
        (state != PER_IDLE && $past(state) != PER_IDLE) |-> $stable(code) && $stable(addr_hold))
        else $error("captured event changed during write-out");

    // sticky status and its clear on read
    a_status_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        !(rd_acc && paddr == PER_OFF_STATUS) |=> (status & $past(status)) == $past(status))
        else $error("status bit lost without a read");
    a_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_acc && paddr == PER_OFF_STATUS && !fire) |=> (status & $past(prdata[3:0])) == 4'h0)
        else $error("status read did not clear reported bits");

    // scenarios for the bench; it reaches all but c_merged and c_store_virt
    c_branch: cover property (@(posedge pclk) disable iff (!presetn)
        fire && ev == 4'h1);
    c_merged: cover property (@(posedge pclk) disable iff (!presetn)
        fire && ev[PER_EN_FETCH] && ev[PER_EN_STORE]);
    c_store_virt: cover property (@(posedge pclk) disable iff (!presetn)
        fire && translation_on && ev[PER_EN_STORE]);
    c_irq_clear: cover property (@(posedge pclk) disable iff (!presetn)
        per_irq ##[1:20] !per_irq);
    c_stall: cover property (@(posedge pclk) disable iff (!presetn)
        fa_we && !fa_ready ##1 fa_we && fa_ready);
endmodule : per_recorder

/* shared/per_pkg.sv */
// per_pkg: constants for the event recorder block.
// assumes a 32-bit apb register bus and a 24-bit instruction address.
package per_pkg;
    // register byte offsets on apb
    localparam logic [7:0] PER_OFF_SELECT = 8'h00;
    localparam logic [7:0] PER_OFF_START = 8'h04;
    localparam logic [7:0] PER_OFF_END = 8'h08;
    localparam logic [7:0] PER_OFF_STATUS = 8'h0c;
    localparam logic [7:0] PER_OFF_MASK = 8'h10;
    localparam logic [7:0] PER_OFF_CODE = 8'h14;
    localparam logic [7:0] PER_OFF_ADDR = 8'h18;
    // enable field positions in the select register
    localparam int PER_EN_BRANCH = 0;
    localparam int PER_EN_GREG = 1;
    localparam int PER_EN_FETCH = 2;
    localparam int PER_EN_STORE = 3;
    localparam int PER_GSEL_LSB = 16;
    localparam int PER_NUM_GREGS = 16;
    // fixed low storage byte locations written on a recorded event
    localparam logic [11:0] PER_LOC_CODE = 12'h096;
    localparam logic [11:0] PER_LOC_ADDR = 12'h099;
    localparam int PER_ADDR_BYTES = 3;
    // reset values
    localparam logic [31:0] PER_RST_REG = 32'h00000000;
    localparam logic [3:0] PER_RST_NIB = 4'h0;
    // fixed-area write sequencer states
    typedef enum logic [2:0] {
        PER_IDLE, PER_WR_CODE, PER_WR_A0, PER_WR_A1, PER_WR_A2
    } per_state_t;
endpackage : per_pkg

/* core/per_range_cmp.sv */
// per_range_cmp: tells whether an address lies in the watched range.
// assumes start and end are in the same address space as the reference.
`timescale 1ns/1ps
module per_range_cmp #(
    parameter int AW = 24
) (
    // bounds
    input wire logic [AW-1:0] range_start,
    input wire logic [AW-1:0] range_end,
    // reference
    input wire logic [AW-1:0] addr,
    output logic hit
);
    // a start above the end wraps around the top of storage
    always_comb begin
        if (range_start <= range_end) begin
            hit = (addr >= range_start) && (addr <= range_end);
        end else begin
            hit = (addr >= range_start) || (addr <= range_end);
        end
    end
endmodule : per_range_cmp

/* tb/tb_per_recorder.sv */
// tb_per_recorder: self-checking bench for the event recorder, apb tasks plus event pulses.
// assumes pready answers on its own and the fixed-area port accepts bytes while fa_ready is high.
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected at %0t: %s got %0h exp %0h", $time, msg, got, exp); end end
module tb_per_recorder;
    import per_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic extended_control_mode, program_status_word_bit1, translation_on, insn_done;
    logic [23:0] insn_addr, fetch_real_addr, fetch_virt_addr, store_real_addr, store_virt_addr, ia;
    logic branch_taken, fetch_valid, store_valid, fa_we, fa_ready, per_irq;
    logic [15:0] greg_written;
    logic [11:0] fa_addr;
    logic [7:0] fa_data;
    logic [3:0] mask_v;
    int failures, samples_checked;

    per_recorder #(.AW(24)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .extended_control_mode(extended_control_mode),
        .program_status_word_bit1(program_status_word_bit1), .translation_on(translation_on),
        .insn_done(insn_done), .insn_addr(insn_addr), .branch_taken(branch_taken),
        .greg_written(greg_written), .fetch_valid(fetch_valid),
        .fetch_real_addr(fetch_real_addr), .fetch_virt_addr(fetch_virt_addr),
        .store_valid(store_valid), .store_real_addr(store_real_addr),
        .store_virt_addr(store_virt_addr), .fa_we(fa_we), .fa_addr(fa_addr),
        .fa_data(fa_data), .fa_ready(fa_ready), .per_irq(per_irq));

    // 25 mhz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // verdict and end of run, also reached on a timeout
    task automatic close_out;
        if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            close_out();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // one completed instruction, then collect accepted fixed-area bytes and check registers
    task automatic fire(input logic br, input logic [15:0] gw, input logic fv, input logic sv,
            input logic [23:0] ra, input logic [23:0] va, input logic [3:0] exp,
            input logic stall);
        logic [11:0] qa[$];
        logic [7:0] qd[$];
        ia = ia + 24'h010203;
        @(posedge pclk);
        insn_done <= 1'b1;
        insn_addr <= ia;
        branch_taken <= br;
        greg_written <= gw;
        fetch_valid <= fv;
        store_valid <= sv;
        fetch_real_addr <= ra;
        store_real_addr <= ra;
        fetch_virt_addr <= va;
        store_virt_addr <= va;
        fa_ready <= !stall; // a stall must hold the first byte in place
        @(posedge pclk);
        insn_done <= 1'b0;
        branch_taken <= 1'b0;
        greg_written <= 16'h0000;
        fetch_valid <= 1'b0;
        store_valid <= 1'b0;
        for (int n = 0; n < 12; n++) begin
            @(posedge pclk);
            if (fa_we === 1'b1 && fa_ready === 1'b1) begin
                qa.push_back(fa_addr);
                qd.push_back(fa_data);
            end
            if (n == 3) fa_ready <= 1'b1;
        end
        `CHK(qa.size(), (exp != 4'h0) ? 4 : 0, "byte count")
        if (exp != 4'h0 && qa.size() == 4) begin
            `CHK(qa[0], 12'h096, "code location")
            `CHK(qd[0], {4'h0, exp}, "code byte")
            `CHK({qa[1], qa[2], qa[3]}, {12'h099, 12'h09a, 12'h09b}, "addr locations")
            `CHK({qd[1], qd[2], qd[3]}, ia, "addr bytes")
        end
        `CHK(per_irq, |(exp & mask_v), "irq level")
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(rd, {28'h0, exp}, "status")
        @(posedge pclk);
        `CHK(per_irq, 1'b0, "irq after clear")
        if (exp != 4'h0) begin
            apb(1'b0, 8'h14, 32'h0);
            `CHK(rd, {28'h0, exp}, "code reg")
            apb(1'b0, 8'h18, 32'h0);
            `CHK(rd, {8'h0, ia}, "addr reg")
        end
    endtask : fire

    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, translation_on, insn_done} = '0;
        {insn_addr, branch_taken, greg_written, fetch_valid, store_valid} = '0;
        {fetch_real_addr, fetch_virt_addr, store_real_addr, store_virt_addr} = '0;
        {extended_control_mode, program_status_word_bit1, fa_ready} = 3'b111;
        {failures, samples_checked, mask_v, ia} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            `CHK(rd, 32'h0, "reset value")
        end
        apb(1'b1, 8'h00, 32'h0020000f);
        apb(1'b1, 8'h04, 32'h00001000);
        apb(1'b1, 8'h08, 32'h00001fff);
        apb(1'b1, 8'h10, 32'h0000000f);
        mask_v = 4'hf;
        apb(1'b0, 8'h00, 32'h0);
        `CHK(rd, 32'h0020000f, "select readback")
        apb(1'b0, 8'h08, 32'h0);
        `CHK(rd, 32'h00001fff, "end readback")
        apb(1'b1, 8'h0c, 32'hf);
        apb(1'b0, 8'h0c, 32'h0);
        `CHK(rd, 32'h0, "status not writable")
        apb(1'b0, 8'h40, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h0}, "unmapped access")
        fire(1, 16'h0000, 0, 0, 24'h0, 24'h0, 4'h1, 0);
        fire(0, 16'h0020, 0, 0, 24'h0, 24'h0, 4'h2, 0);
        fire(0, 16'h0040, 0, 0, 24'h0, 24'h0, 4'h0, 0);
        fire(0, 16'h0000, 1, 0, 24'h001000, 24'h0, 4'h4, 0);
        fire(0, 16'h0000, 0, 1, 24'h001fff, 24'h0, 4'h8, 1);
        fire(0, 16'h0000, 1, 1, 24'h002000, 24'h001500, 4'h0, 0);
        translation_on <= 1'b1;
        fire(0, 16'h0000, 1, 0, 24'h005000, 24'h001800, 4'h4, 0);
        fire(0, 16'h0000, 0, 1, 24'h001800, 24'h005000, 4'h0, 0);
        translation_on <= 1'b0;
        fire(1, 16'h0020, 0, 1, 24'h001800, 24'h0, 4'hb, 1);
        program_status_word_bit1 <= 1'b0;
        fire(1, 16'h0020, 1, 1, 24'h001800, 24'h0, 4'h0, 0);
        program_status_word_bit1 <= 1'b1;
        extended_control_mode <= 1'b0;
        fire(1, 16'h0000, 1, 0, 24'h001800, 24'h0, 4'h0, 0);
        extended_control_mode <= 1'b1;
        fire(0, 16'h0000, 0, 0, 24'h0, 24'h0, 4'h0, 0);
        apb(1'b1, 8'h00, 32'h0020000e);
        fire(1, 16'h0000, 0, 0, 24'h0, 24'h0, 4'h0, 0);
        apb(1'b1, 8'h10, 32'h0);
        mask_v = 4'h0;
        fire(0, 16'h0020, 0, 0, 24'h0, 24'h0, 4'h2, 0);
        close_out();
    end
endmodule : tb_per_recorder
